// ===== shared/srb_pkg.sv
// Shared constants, types and helpers for the reset-state register bank
`default_nettype none
package srb_pkg;
    // Avalon word address width and register word indices
    localparam int unsigned SRB_AW = 3;
    localparam logic [2:0] SRB_IDX_RCAUSE = 3'h0;
    localparam logic [2:0] SRB_IDX_OSC = 3'h1;
    localparam logic [2:0] SRB_IDX_RTC = 3'h2;
    localparam logic [2:0] SRB_IDX_NVM = 3'h3;
    localparam logic [2:0] SRB_IDX_IPC_ADC = 3'h4;
    localparam logic [2:0] SRB_IDX_IRQ_PRIORITY_CTRL_THREE = 3'h5;

    // Priority registers: reset values and implemented-bit masks
    localparam logic [15:0] SRB_IRQ_PRIORITY_CTRL_THREE_RST = 16'h4444;
    localparam logic [15:0] SRB_IRQ_PRIORITY_CTRL_THREE_MASK = 16'h7777;
    localparam logic [15:0] SRB_IPC_ADC_RST = 16'h0044;
    localparam logic [15:0] SRB_IPC_ADC_MASK = 16'h0077;
    localparam int unsigned SRB_FLD_HI = 12;
    localparam int unsigned SRB_FLD_MH = 8;
    localparam int unsigned SRB_FLD_ML = 4;
    localparam int unsigned SRB_FLD_LO = 0;

    // Oscillator control layout
    localparam int unsigned SRB_OSC_CUR_LSB = 0;
    localparam int unsigned SRB_OSC_NEW_LSB = 4;
    localparam int unsigned SRB_OSC_COLD_BIT = 15;
    localparam logic [15:0] SRB_OSC_RST = 16'h0000;
    localparam logic [15:0] SRB_OSC_WMASK = 16'h0070;

    // Reset cause, calibration and nonvolatile control
    localparam logic [15:0] SRB_RCAUSE_WMASK = 16'h00ff;
    localparam logic [15:0] SRB_RTC_POR = 16'h0000;
    localparam logic [15:0] SRB_NVM_POR = 16'h0000;

    typedef logic [2:0] srb_prio_t;

    // Kind of the reset just released, one bit per source
    typedef struct packed {
        logic cfg_mismatch;
        logic illegal_op;
        logic trap;
        logic sw_reset;
        logic wdt;
        logic ext_reset;
        logic brownout;
        logic power_on;
    } srb_cause_s;

    typedef struct packed {
        logic [SRB_AW-1:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } srb_avm_req_s;

    typedef struct packed {
        srb_prio_t serial_port3_event_priority;
        srb_prio_t serial_port3_fault_priority;
        srb_prio_t uart4_transmit_priority;
        srb_prio_t uart4_receive_priority;
        srb_prio_t adc_done_priority;
        srb_prio_t uart1_transmit_priority;
    } srb_prio_s;

    typedef enum logic {SRB_LOAD, SRB_RUN} srb_state_e;

    // Byte enables widened to a 16-bit bit mask
    function automatic logic [15:0] srb_be_mask(input logic [3:0] be);
        srb_be_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction

    // Merge write data into an old value under a bit mask
    function automatic logic [15:0] srb_merge(input logic [15:0] old_v,
        input logic [15:0] new_v, input logic [15:0] mask);
        srb_merge = (old_v & ~mask) | (new_v & mask);
    endfunction
endpackage
`default_nettype wire

// ===== hw/srb_prio_reg.sv
// One interrupt priority register with masked writes
`timescale 1ns/100ps
`default_nettype none
module srb_prio_reg import srb_pkg::*; #(
    parameter logic [15:0] RST_VAL = 16'h0000,
    parameter logic [15:0] IMPL_MASK = 16'hffff
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    input wire logic [15:0] wr_mask,
    output logic [15:0] value_r
);
    logic [15:0] value_nxt;

    // Unimplemented bits never take write data, so they stay zero
    always_comb begin
        value_nxt = value_r;
        if (wr_en) begin
            value_nxt = srb_merge(value_r, wr_data, wr_mask & IMPL_MASK);
        end
    end

    // Every field comes out of reset at the level that RST_VAL gives it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            value_r <= RST_VAL;
        end else begin
            value_r <= value_nxt;
        end
    end

    property p_unimpl_zero;
        @(posedge clock) disable iff (!rst_n)
        (value_r & ~IMPL_MASK) == 16'h0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented priority bit is set");

    property p_wr_takes;
        @(posedge clock) disable iff (!rst_n)
        wr_en |=> value_r == srb_merge($past(value_r), $past(wr_data),
            $past(wr_mask) & IMPL_MASK);
    endproperty
    a_wr_takes: assert property (p_wr_takes)
        else $error("priority register did not take the write");
endmodule
`default_nettype wire

// ===== hw/srb_regs.sv
// Reset-state register bank with interrupt priority registers
`timescale 1ns/100ps
`default_nettype none
module srb_regs import srb_pkg::*; (
    input wire logic clock,
    input wire logic rst_n,
    input wire srb_cause_s reset_cause,
    input wire logic [2:0] initial_oscillator_select,
    input wire srb_avm_req_s avm_req,
    output logic avm_waitrequest,
    output logic [31:0] avm_readdata,
    output srb_prio_s prio_levels,
    output logic [2:0] osc_current_select,
    output logic [2:0] osc_new_select
);
    // State cleared by every reset
    typedef struct packed {
        srb_state_e state;
        logic waitrequest;
        logic [31:0] readdata;
        logic [15:0] osc;
    } srb_core_s;

    // State that only power-on, software or the cause of a warm reset may change
    typedef struct packed {
        logic [15:0] rcause;
        logic [15:0] rtc;
        logic [15:0] nvm;
    } srb_keep_s;

    srb_core_s core_r;
    srb_core_s core_nxt;
    srb_keep_s keep_r;
    srb_keep_s keep_nxt;
    logic [15:0] irq_priority_ctrl_three_r;
    logic [15:0] ipc_adc_r;
    logic go;
    logic loading;
    logic [15:0] wmask;
    logic [15:0] wdata;
    logic [15:0] rd_val;

    // One request accepted per handshake; never while loading
    assign loading = (core_r.state == SRB_LOAD);
    assign go = !loading && core_r.waitrequest &&
        (avm_req.read || avm_req.write);
    assign wmask = srb_be_mask(avm_req.byteenable);
    assign wdata = avm_req.writedata[15:0];

    // Read mux; unmapped words read as zero
    always_comb begin
        rd_val = 16'h0000;
        if (avm_req.address == SRB_IDX_RCAUSE) begin
            rd_val = keep_r.rcause;
        end else if (avm_req.address == SRB_IDX_OSC) begin
            rd_val = core_r.osc;
        end else if (avm_req.address == SRB_IDX_RTC) begin
            rd_val = keep_r.rtc;
        end else if (avm_req.address == SRB_IDX_NVM) begin
            rd_val = keep_r.nvm;
        end else if (avm_req.address == SRB_IDX_IPC_ADC) begin
            rd_val = ipc_adc_r;
        end else if (avm_req.address == SRB_IDX_IRQ_PRIORITY_CTRL_THREE) begin
            rd_val = irq_priority_ctrl_three_r;
        end
    end

    // Priority registers: plain fixed defaults on any reset
    srb_prio_reg #(
        .RST_VAL(SRB_IRQ_PRIORITY_CTRL_THREE_RST),
        .IMPL_MASK(SRB_IRQ_PRIORITY_CTRL_THREE_MASK)
    ) u_irq_priority_ctrl_three (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(go && avm_req.write && avm_req.address == SRB_IDX_IRQ_PRIORITY_CTRL_THREE),
        .wr_data(wdata),
        .wr_mask(wmask),
        .value_r(irq_priority_ctrl_three_r)
    );

    srb_prio_reg #(
        .RST_VAL(SRB_IPC_ADC_RST),
        .IMPL_MASK(SRB_IPC_ADC_MASK)
    ) u_ipc_adc (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(go && avm_req.write && avm_req.address == SRB_IDX_IPC_ADC),
        .wr_data(wdata),
        .wr_mask(wmask),
        .value_r(ipc_adc_r)
    );

    // Core: one load cycle after release, then bus service
    always_comb begin
        core_nxt = core_r;
        core_nxt.waitrequest = 1'b1;
        case (core_r.state)
            SRB_LOAD: begin
                // Cause and strap are caught here, not under reset
                core_nxt.osc = SRB_OSC_RST;
                core_nxt.osc[SRB_OSC_CUR_LSB +: 3] =
                    initial_oscillator_select;
                core_nxt.osc[SRB_OSC_NEW_LSB +: 3] =
                    initial_oscillator_select;
                core_nxt.osc[SRB_OSC_COLD_BIT] = reset_cause.power_on;
                core_nxt.state = SRB_RUN;
            end
            SRB_RUN: begin
                if (go) begin
                    core_nxt.waitrequest = 1'b0;
                    if (avm_req.read) begin
                        core_nxt.readdata = {16'h0000, rd_val};
                    end
                    if (avm_req.write && avm_req.address == SRB_IDX_OSC) begin
                        core_nxt.osc = srb_merge(core_r.osc, wdata,
                            wmask & SRB_OSC_WMASK);
                    end
                end
            end
            default: core_nxt.state = SRB_LOAD;
        endcase
    end

    // Retained registers: power-on loads, other resets keep rtc and nvm and add their cause to rcause
    always_comb begin
        keep_nxt = keep_r;
        if (loading) begin
            if (reset_cause.power_on) begin
                keep_nxt.rcause = {8'h00, reset_cause};
                keep_nxt.rtc = SRB_RTC_POR;
                keep_nxt.nvm = SRB_NVM_POR;
            end else begin
                // Earlier causes accumulate until software clears them
                keep_nxt.rcause = keep_r.rcause | {8'h00, reset_cause};
            end
        end else if (go && avm_req.write) begin
            if (avm_req.address == SRB_IDX_RCAUSE) begin
                keep_nxt.rcause = srb_merge(keep_r.rcause, wdata,
                    wmask & SRB_RCAUSE_WMASK);
            end else if (avm_req.address == SRB_IDX_RTC) begin
                keep_nxt.rtc = srb_merge(keep_r.rtc, wdata, wmask);
            end else if (avm_req.address == SRB_IDX_NVM) begin
                keep_nxt.nvm = srb_merge(keep_r.nvm, wdata, wmask);
            end
        end
    end

    // Core state starts from constants on every reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            core_r.state <= SRB_LOAD;
            core_r.waitrequest <= 1'b1;
            core_r.readdata <= 32'h0000_0000;
            core_r.osc <= SRB_OSC_RST;
        end else begin
            core_r <= core_nxt;
        end
    end

    // No reset here: contents must survive non-power-on resets
    always_ff @(posedge clock) begin
        if (rst_n) begin
            keep_r <= keep_nxt;
        end
    end

    // Outputs taken straight from flops; zero level disables a source
    assign avm_waitrequest = core_r.waitrequest;
    assign avm_readdata = core_r.readdata;
    assign osc_current_select = core_r.osc[SRB_OSC_CUR_LSB +: 3];
    assign osc_new_select = core_r.osc[SRB_OSC_NEW_LSB +: 3];
    assign prio_levels.serial_port3_event_priority =
        irq_priority_ctrl_three_r[SRB_FLD_HI +: 3];
    assign prio_levels.serial_port3_fault_priority = irq_priority_ctrl_three_r[SRB_FLD_MH +: 3];
    assign prio_levels.uart4_transmit_priority = irq_priority_ctrl_three_r[SRB_FLD_ML +: 3];
    assign prio_levels.uart4_receive_priority = irq_priority_ctrl_three_r[SRB_FLD_LO +: 3];
    assign prio_levels.adc_done_priority = ipc_adc_r[SRB_FLD_ML +: 3];
    assign prio_levels.uart1_transmit_priority = ipc_adc_r[SRB_FLD_LO +: 3];

    property p_load_defaults;
        @(posedge clock) disable iff (!rst_n)
        loading |-> irq_priority_ctrl_three_r == SRB_IRQ_PRIORITY_CTRL_THREE_RST && ipc_adc_r == SRB_IPC_ADC_RST;
    endproperty
    a_load_defaults: assert property (p_load_defaults)
        else $error("priority defaults wrong after reset");

    property p_load_once;
        @(posedge clock) disable iff (!rst_n)
        loading |=> !loading && avm_waitrequest;
    endproperty
    a_load_once: assert property (p_load_once)
        else $error("load phase did not end after one cycle");

    property p_cause_por;
        @(posedge clock) disable iff (!rst_n)
        loading && reset_cause.power_on |=>
            keep_r.rcause == {8'h00, $past(reset_cause)};
    endproperty
    a_cause_por: assert property (p_cause_por)
        else $error("reset cause not loaded on power-on");

    property p_cause_warm;
        @(posedge clock) disable iff (!rst_n)
        loading && !reset_cause.power_on |=>
            keep_r.rcause == ($past(keep_r.rcause) | {8'h00, $past(reset_cause)});
    endproperty
    a_cause_warm: assert property (p_cause_warm)
        else $error("reset cause not accumulated on warm reset");

    property p_osc_load;
        @(posedge clock) disable iff (!rst_n)
        loading |=> osc_current_select == $past(initial_oscillator_select)
            && core_r.osc[SRB_OSC_COLD_BIT] == $past(reset_cause.power_on);
    endproperty
    a_osc_load: assert property (p_osc_load)
        else $error("oscillator control reset value wrong");

    property p_keep_warm;
        @(posedge clock) disable iff (!rst_n)
        loading && !reset_cause.power_on |=>
            $stable(keep_r.rtc) && $stable(keep_r.nvm);
    endproperty
    a_keep_warm: assert property (p_keep_warm)
        else $error("retained register changed on warm reset");

    sequence s_ack;
        !avm_waitrequest ##1 avm_waitrequest;
    endsequence
    property p_bus_ack;
        @(posedge clock) disable iff (!rst_n)
        go |=> s_ack;
    endproperty
    a_bus_ack: assert property (p_bus_ack)
        else $error("bus answer not a single cycle");

    property p_field_zero;
        @(posedge clock) disable iff (!rst_n)
        go && avm_req.write && avm_req.address == SRB_IDX_IRQ_PRIORITY_CTRL_THREE &&
            avm_req.byteenable[1] && avm_req.writedata[14:12] == 3'h0 |=>
            prio_levels.serial_port3_event_priority == 3'h0;
    endproperty
    a_field_zero: assert property (p_field_zero)
        else $error("zero write did not disable the source");
endmodule
`default_nettype wire

// ===== tb/test_sfr_reset_and_irq_priority_regs.sv
// Self-checking bench for the reset-state register bank
`timescale 1ns/100ps
`default_nettype none
module test_sfr_reset_and_irq_priority_regs import srb_pkg::*;;
    logic clock;
    logic rst_n;
    srb_cause_s reset_cause;
    logic [2:0] strap;
    srb_avm_req_s req;
    logic avm_waitrequest;
    logic [31:0] avm_readdata;
    srb_prio_s prio_levels;
    logic [2:0] osc_cur;
    logic [2:0] osc_new;
    int err_total;
    int cmp_count;
    int cyc = 0;
    int mdl [8];
    logic [31:0] rd;

    srb_regs u_dut (
        .clock(clock),
        .rst_n(rst_n),
        .reset_cause(reset_cause),
        .initial_oscillator_select(strap),
        .avm_req(req),
        .avm_waitrequest(avm_waitrequest),
        .avm_readdata(avm_readdata),
        .prio_levels(prio_levels),
        .osc_current_select(osc_cur),
        .osc_new_select(osc_new)
    );

    // 50 MHz system clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Hang guard, far above the roughly seven hundred cycles the run needs
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            $display("ERROR %0t: run timed out", $time);
            complete_run();
        end
    end

    task automatic complete_run();
        $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Writable bits per word; read-only and gap bits stay out
    function automatic logic [15:0] wmask(input int a);
        case (a)
            0: wmask = SRB_RCAUSE_WMASK;
            1: wmask = SRB_OSC_WMASK;
            2, 3: wmask = 16'hffff;
            4: wmask = SRB_IPC_ADC_MASK;
            5: wmask = SRB_IRQ_PRIORITY_CTRL_THREE_MASK;
            default: wmask = 16'h0000;
        endcase
    endfunction

    // One Avalon transfer; request held until waitrequest is seen low
    // Sampled right after the rising edge, so the values read are those
    // the design showed at that edge; only the hang guard ends a wait
    task automatic bus(input int a, input logic rdn, input logic [31:0] wd,
        input logic [3:0] be, output logic [31:0] q);
        @(posedge clock);
        req.address <= 3'(a);
        req.read <= rdn;
        req.write <= ~rdn;
        req.writedata <= wd;
        req.byteenable <= be;
        do begin
            @(posedge clock);
        end while (avm_waitrequest !== 1'b0);
        q = avm_readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask

    task automatic wr(input int a, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] q;
        logic [15:0] m;
        m = wmask(a) & {{8{be[1]}}, {8{be[0]}}};
        bus(a, 1'b0, wd, be, q);
        mdl[a] = (mdl[a] & ~m) | (wd[15:0] & m);
    endtask

    // Read every word, unmapped ones included, and the field outputs
    task automatic check_all();
        logic [31:0] q;
        for (int a = 0; a < 8; a++) begin
            bus(a, 1'b1, 32'h0, 4'h0, q);
            check(q, 32'(mdl[a]));
        end
        check({14'h0, prio_levels}, {14'h0, mdl[5][14:12], mdl[5][10:8],
            mdl[5][6:4], mdl[5][2:0], mdl[4][6:4], mdl[4][2:0]});
        check({29'h0, osc_cur}, 32'(mdl[1] & 7));
        check({29'h0, osc_new}, 32'((mdl[1] >> 4) & 7));
    endtask

    // Reset of a given kind; cause and strap scrambled after the load
    task automatic do_reset(input logic [7:0] c, input logic [2:0] s);
        @(posedge clock);
        rst_n <= 1'b0;
        reset_cause <= c;
        strap <= s;
        repeat (10) @(posedge clock);
        check({31'h0, avm_waitrequest}, 32'h1);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        reset_cause <= 8'($urandom);
        strap <= 3'($urandom);
        if (c[0]) begin
            mdl[0] = c;
            mdl[2] = 0;
            mdl[3] = 0;
        end else begin
            mdl[0] = mdl[0] | c;
        end
        // Current and new select both come up at the strap value
        mdl[1] = s | (s << 4) | (c[0] ? 32'h8000 : 32'h0);
        mdl[4] = 16'h0044;
        mdl[5] = 16'h4444;
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        reset_cause = 8'h01;
        strap = 3'h0;
        req = '0;
        err_total = 0;
        cmp_count = 0;
        for (int a = 0; a < 8; a++) begin
            mdl[a] = 0;
        end
        rd = $urandom(32'h89ee0543);
        do_reset(8'h01, 3'h5);
        check_all();
        $display("test power_on_defaults done");
        // All ones then all zeros: levels 7 and disabled, gaps stay zero
        for (int a = 0; a < 8; a++) begin
            wr(a, 32'hffffffff, 4'hf);
        end
        check_all();
        for (int a = 0; a < 8; a++) begin
            wr(a, 32'h0, 4'h3);
        end
        check_all();
        $display("test write_extremes done");
        repeat (4) begin
            repeat (10) wr($urandom_range(7), $urandom, 4'($urandom));
            check_all();
        end
        $display("test random_access done");
        // Each non-power-on kind: calibration and memory control survive
        for (int k = 1; k < 8; k++) begin
            wr(0, $urandom, 4'h1);
            wr(2, $urandom, 4'h3);
            wr(3, $urandom, 4'h3);
            wr(5, $urandom, 4'h3);
            do_reset(8'(1 << k), 3'($urandom));
            check_all();
        end
        $display("test warm_resets done");
        do_reset(8'($urandom) | 8'h01, 3'($urandom));
        check_all();
        $display("test second_power_on done");
        complete_run();
    end
endmodule
`default_nettype wire
